// [common/dpgs_cfg.svh]
`ifndef DPGS_CFG_SVH
`define DPGS_CFG_SVH

// Build variant: 8 for the octal part, 4 for the quad part
`define DPGS_CHANNELS        8

// Serial register addresses
`define DPGS_ADDR_PD_VOL     5'h09
`define DPGS_ADDR_GAIN_STAT  5'h0A
`define DPGS_ADDR_PD_NV      5'h19
// Address bit that marks the nonvolatile half of the map
`define DPGS_NV_SPACE_BIT    4

// Field positions in the gain and status word
`define DPGS_GAIN_LSB        8
`define DPGS_POR_FLAG_BIT    7
`define DPGS_NONVOLATILE_WRITE_ACTIVE_FLAG_BIT        6

// Reset values
`define DPGS_PD_RESET        16'h0000
`define DPGS_GAIN_RESET      8'h00
`define DPGS_POR_FLAG_RESET  1'b1

// Nonvolatile write cycle time, rounded up to whole clocks
`define DPGS_CLK_PERIOD_NS   4
`define DPGS_EE_WRITE_NS     1000
`define DPGS_EE_WRITE_CYCLES \
    ((`DPGS_EE_WRITE_NS + `DPGS_CLK_PERIOD_NS - 1) / `DPGS_CLK_PERIOD_NS)

`endif

// [common/dpgs_pkg.sv]
package dpgs_pkg;

    typedef enum logic [1:0]
    {
        PD_NORMAL = 2'b00,
        PD_LOAD_1K = 2'b01,
        PD_LOAD_125K = 2'b10,
        PD_OPEN = 2'b11
    } dpgs_pd_mode_t;

    // One register command from the serial protocol engine
    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } dpgs_req_t;

    // Answer, one cycle after the command
    typedef struct packed
    {
        logic        ack;
        logic        nak;
        logic [15:0] rdata;
    } dpgs_rsp_t;

endpackage

// [rtl/dpgs_chan_decode.sv]
`timescale 1ns/1ps

module dpgs_chan_decode
    import dpgs_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // Power-down field of one channel
    input  wire dpgs_pd_mode_t mode,
    // Output stage controls
    output logic               drive_en,
    output logic               load_1k,
    output logic               load_125k
);

    logic next_drive_en;
    logic next_load_1k;
    logic next_load_125k;

    assign next_drive_en  = (mode == PD_NORMAL);
    assign next_load_1k   = (mode == PD_LOAD_1K);
    // field 11 matches none, output open
    assign next_load_125k = (mode == PD_LOAD_125K);

    // Registered so the analogue switches never see decode glitches
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            drive_en  <= 1'b0;
            load_1k   <= 1'b0;
            load_125k <= 1'b0;
        end
        else
        begin
            drive_en  <= next_drive_en;
            load_1k   <= next_load_1k;
            load_125k <= next_load_125k;
        end
    end

endmodule

// [rtl/dpgs_ee_timer.sv]
`timescale 1ns/1ps
`include "dpgs_cfg.svh"

module dpgs_ee_timer
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Start of a nonvolatile write
    input  wire logic start,
    // Write cycle in progress
    output logic      busy
);

    localparam logic [15:0] CYCLES = 16'(`DPGS_EE_WRITE_CYCLES);

    logic [15:0] count;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy  <= 1'b0;
            count <= 16'h0000;
        end
        else if (start && !busy)
        begin
            busy  <= 1'b1;
            count <= CYCLES - 16'h0001;
        end
        else if (busy)
        begin
            busy  <= (count != 16'h0000);
            count <= (count != 16'h0000) ? count - 16'h0001 : 16'h0000;
        end
    end

    // Busy lasts exactly the write time
    busy_length_a: assert property (@(posedge clk) disable iff (!resetn)
        $fell(busy) |-> count == 16'h0000)
        else $error("write cycle ended with time left");

endmodule

// [rtl/dpgs_regs.sv]
`timescale 1ns/1ps
`include "dpgs_cfg.svh"

// What this block does
// - Power-down register: volatile copy at 09h, nonvolatile copy at 19h.
// - Every channel owns a two-bit power-down field.
// - Fields fill bits 15-0 on octal, 7-0 on quad.
// - Field 00 runs the channel normally with output driven.
// - Field 01 powers down with 1k load to ground.
// - Field 10 powers down with 125k load to ground.
// - Field 11 powers down with output left open.
// - Quad unused power-down bits 15-8; they are masked and read as zero.
// - Gain and status register sits at 0Ah.
// - One gain bit per channel from bit 8 up; one means 2x.
// - Reset-event flag in bit 7 sets on reset, clears on read.
// - Bit 6 reads one while a nonvolatile write runs.
// - During a nonvolatile write only volatile commands are accepted.
module dpgs_regs
    import dpgs_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Register commands from the serial engine
    input  wire dpgs_req_t                  req,
    output dpgs_rsp_t                       rsp,
    // Brown-out seen while logic stays powered
    input  wire logic                       brownout_event,
    // Stored images recalled after reset
    input  wire logic [15:0]                nv_pd_image,
    input  wire logic [7:0]                 nv_gain_image,
    // Nonvolatile programming
    output logic                            ee_wr_req,
    output logic [15:0]                     ee_wr_data,
    output logic                            write_active,
    // Channel output stage controls
    output logic [`DPGS_CHANNELS-1:0]       ch_drive_en,
    output logic [`DPGS_CHANNELS-1:0]       ch_load_1k,
    output logic [`DPGS_CHANNELS-1:0]       ch_load_125k,
    output logic [`DPGS_CHANNELS-1:0]       ch_gain
);

    localparam int CH = `DPGS_CHANNELS;
    localparam logic [15:0] PD_MASK = 16'((32'h1 << (2 * CH)) - 32'h1);
    localparam logic [7:0] GAIN_MASK = 8'((32'h1 << CH) - 32'h1);

    logic [15:0] pd_vol;
    logic [15:0] pd_nv;
    logic [7:0]  gain;
    logic        por_flag;
    logic        loaded;

    logic        hit_pdv;
    logic        hit_gs;
    logic        hit_pdn;
    logic        nv_space;
    logic        any_cmd;
    logic        mapped;
    logic        refused;
    logic        take;
    logic        wr_pdv;
    logic        wr_gain;
    logic        wr_pdn;
    logic        rd_gs;
    logic [15:0] status_word;
    logic [15:0] read_word;
    logic        next_por_flag;
    logic [15:0] busy_len;

    // Address decode
    assign hit_pdv  = (req.addr == `DPGS_ADDR_PD_VOL);
    assign hit_gs   = (req.addr == `DPGS_ADDR_GAIN_STAT);
    assign hit_pdn  = (req.addr == `DPGS_ADDR_PD_NV);
    assign nv_space = req.addr[`DPGS_NV_SPACE_BIT];
    assign any_cmd  = req.rd || req.wr;
    assign mapped   = hit_pdv || hit_gs || hit_pdn;

    // every command refused until recall, nonvolatile commands refused while busy
    // Reads of the nonvolatile half are refused too while it is busy
    assign refused = !loaded || (nv_space && write_active);
    assign take    = any_cmd && mapped && !refused;

    assign wr_pdv  = take && req.wr && hit_pdv;
    assign wr_pdn  = take && req.wr && hit_pdn;
    assign wr_gain = take && req.wr && hit_gs;
    assign rd_gs   = take && req.rd && hit_gs;

    // bit 6 mirrors the write timer
    assign status_word = {gain & GAIN_MASK, por_flag, write_active, 6'h00};

    // unused bits read as zero, masked at write
    assign read_word = hit_pdv ? (pd_vol & PD_MASK) :
                       hit_pdn ? (pd_nv & PD_MASK) :
                       hit_gs  ? status_word : 16'h0000;

    // a new event beats the read clear
    // set on event, cleared by read
    assign next_por_flag = brownout_event ? 1'b1 :
                           rd_gs          ? 1'b0 : por_flag;

    // Recall of stored images in the first cycle after release
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            loaded <= 1'b0;
        end
        else
        begin
            loaded <= 1'b1;
        end
    end

    // fields masked to the variant width
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pd_vol <= `DPGS_PD_RESET;
            pd_nv  <= `DPGS_PD_RESET;
        end
        else if (!loaded)
        begin
            pd_vol <= nv_pd_image & PD_MASK;
            pd_nv  <= nv_pd_image & PD_MASK;
        end
        else
        begin
            if (wr_pdv)
            begin
                pd_vol <= req.wdata & PD_MASK;
            end
            if (wr_pdn)
            begin
                pd_nv <= req.wdata & PD_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gain <= `DPGS_GAIN_RESET;
        end
        else if (!loaded)
        begin
            gain <= nv_gain_image & GAIN_MASK;
        end
        else if (wr_gain)
        begin
            gain <= req.wdata[`DPGS_GAIN_LSB +: 8] & GAIN_MASK;
        end
    end

    // flag set by the reset itself
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            por_flag <= `DPGS_POR_FLAG_RESET;
        end
        else
        begin
            por_flag <= next_por_flag;
        end
    end

    // Answer one cycle after the command
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.ack   <= take;
            rsp.nak   <= any_cmd && !take;
            rsp.rdata <= (take && req.rd) ? read_word : 16'h0000;
        end
    end

    // nonvolatile copy goes to the array
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ee_wr_req  <= 1'b0;
            ee_wr_data <= 16'h0000;
        end
        else
        begin
            ee_wr_req  <= wr_pdn;
            ee_wr_data <= wr_pdn ? (req.wdata & PD_MASK) : ee_wr_data;
        end
    end

    dpgs_ee_timer u_ee_timer
    (
        .clk    (clk),
        .resetn (resetn),
        .start  (wr_pdn),
        .busy   (write_active)
    );

    // write time measured apart from the timer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_len <= 16'h0000;
        end
        else
        begin
            busy_len <= write_active ? busy_len + 16'h0001 : 16'h0000;
        end
    end

    assign ch_gain = gain[CH-1:0];

    // channel n decodes bits 2n+1 and 2n
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++)
        begin : g_chan
            dpgs_chan_decode u_decode
            (
                .clk       (clk),
                .resetn    (resetn),
                .mode      (dpgs_pd_mode_t'(pd_vol[2*gi +: 2])),
                .drive_en  (ch_drive_en[gi]),
                .load_1k   (ch_load_1k[gi]),
                .load_125k (ch_load_125k[gi])
            );
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence nv_write_s;
        req.wr && hit_pdn && loaded && !write_active;
    endsequence

    sequence nv_start_s;
        ee_wr_req && write_active;
    endsequence

    pdv_write_a: assert property (
        req.wr && hit_pdv && loaded |=> pd_vol == ($past(req.wdata) & PD_MASK))
        else $error("volatile power-down write not stored");

    pd_normal_a: assert property (
        pd_vol[1:0] == 2'b00 |=> ch_drive_en[0] && !ch_load_1k[0] && !ch_load_125k[0])
        else $error("normal mode not driving");

    pd_load1k_a: assert property (
        pd_vol[3:2] == 2'b01 |=> !ch_drive_en[1] && ch_load_1k[1] && !ch_load_125k[1])
        else $error("1k load mode wrong");

    pd_load125k_a: assert property (
        pd_vol[5:4] == 2'b10 |=> !ch_drive_en[2] && !ch_load_1k[2] && ch_load_125k[2])
        else $error("125k load mode wrong");

    pd_open_a: assert property (
        pd_vol[2*CH-1 -: 2] == 2'b11
        |=> !ch_drive_en[CH-1] && !ch_load_1k[CH-1] && !ch_load_125k[CH-1])
        else $error("open mode wrong");

    gain_read_a: assert property (
        req.rd && hit_gs && loaded |=> rsp.ack && rsp.rdata[15:8] == $past(gain))
        else $error("gain bits misread");

    por_read_a: assert property (
        req.rd && hit_gs && loaded && !brownout_event
        |=> !por_flag && rsp.rdata[7] == $past(por_flag))
        else $error("reset flag not served then cleared");

    por_set_wins_a: assert property (
        brownout_event |=> por_flag)
        else $error("reset event lost");

    nv_write_busy_a: assert property (
        nv_write_s |=> nv_start_s ##1 write_active)
        else $error("write cycle did not start");

    nv_refused_a: assert property (
        req.wr && hit_pdn && write_active |=> rsp.nak && !ee_wr_req && $stable(pd_nv))
        else $error("nonvolatile write taken while busy");

    pd_field_mask_a: assert property (
        (pd_vol & ~PD_MASK) == 16'h0000 && (pd_nv & ~PD_MASK) == 16'h0000)
        else $error("unused power-down bits set");

    write_time_a: assert property (
        $fell(write_active) |-> busy_len == 16'(`DPGS_EE_WRITE_CYCLES))
        else $error("write cycle length wrong");

endmodule

// [test/dpgs_host_model.sv]
`timescale 1ns/1ps

module dpgs_host_model
    import dpgs_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Register port
    output dpgs_req_t      req,
    input  wire dpgs_rsp_t rsp
);
    initial
    begin
        req = '0;
    end

    // one command outstanding
    // Request held up to the taking edge; idle fields show inverted junk, not old values
    task automatic cmd(input logic rd, input logic wr, input logic [4:0] addr,
                       input logic [15:0] wdata, output dpgs_rsp_t r);
        @(posedge clk);
        #1;
        req = '{rd: rd, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        r = rsp;
    endtask
endmodule

// [test/dpgs_regs_tb_top.sv]
`timescale 1ns/1ps
`include "dpgs_cfg.svh"

`define CHK(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
            n_fail++; \
        end \
    end

module dpgs_regs_tb_top;
    import dpgs_pkg::*;

    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        ack;
        logic        nak;
        logic [15:0] rdata;
    } dpgs_row_t;

    // Images 1B36 / A5 put every mode on some channel at recall
    localparam dpgs_row_t ROWS [11] = '{
        '{1'b1, 1'b0, 5'h09, 16'h0000, 1'b1, 1'b0, 16'h1B36},
        '{1'b1, 1'b0, 5'h0A, 16'h0000, 1'b1, 1'b0, 16'hA580},
        '{1'b1, 1'b0, 5'h0A, 16'h0000, 1'b1, 1'b0, 16'hA500},
        '{1'b0, 1'b1, 5'h09, 16'h5AA5, 1'b1, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 5'h09, 16'h0000, 1'b1, 1'b0, 16'h5AA5},
        '{1'b0, 1'b1, 5'h09, 16'hE41B, 1'b1, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 5'h09, 16'h0000, 1'b1, 1'b0, 16'hE41B},
        '{1'b0, 1'b1, 5'h0A, 16'hFFFF, 1'b1, 1'b0, 16'h0000},
        '{1'b1, 1'b0, 5'h0A, 16'h0000, 1'b1, 1'b0, 16'hFF00},
        '{1'b1, 1'b0, 5'h05, 16'h0000, 1'b0, 1'b1, 16'h0000},
        '{1'b0, 1'b1, 5'h1F, 16'h1234, 1'b0, 1'b1, 16'h0000}
    };

    logic                     clk;
    logic                     resetn;
    dpgs_req_t                req;
    dpgs_rsp_t                rsp;
    dpgs_rsp_t                r;
    logic                     brownout_event;
    logic [15:0]              nv_pd_image;
    logic [7:0]               nv_gain_image;
    logic                     ee_wr_req;
    logic [15:0]              ee_wr_data;
    logic                     write_active;
    logic [`DPGS_CHANNELS-1:0] ch_drive_en;
    logic [`DPGS_CHANNELS-1:0] ch_load_1k;
    logic [`DPGS_CHANNELS-1:0] ch_load_125k;
    logic [`DPGS_CHANNELS-1:0] ch_gain;
    int                       n_fail;
    int                       check_count;
    int                       cycles;

    dpgs_regs i_dpgs_regs (
        .clk            (clk),
        .resetn         (resetn),
        .req            (req),
        .rsp            (rsp),
        .brownout_event (brownout_event),
        .nv_pd_image    (nv_pd_image),
        .nv_gain_image  (nv_gain_image),
        .ee_wr_req      (ee_wr_req),
        .ee_wr_data     (ee_wr_data),
        .write_active   (write_active),
        .ch_drive_en    (ch_drive_en),
        .ch_load_1k     (ch_load_1k),
        .ch_load_125k   (ch_load_125k),
        .ch_gain        (ch_gain)
    );

    dpgs_host_model i_dpgs_host_model (
        .clk (clk),
        .req (req),
        .rsp (rsp)
    );

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run is well under 1000 cycles; the write cycle alone is 250
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial
    begin
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        resetn = 1'b0;
        brownout_event = 1'b0;
        nv_pd_image = 16'h1B36;
        nv_gain_image = 8'hA5;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        foreach (ROWS[i])
        begin
            i_dpgs_host_model.cmd(ROWS[i].rd, ROWS[i].wr, ROWS[i].addr, ROWS[i].wdata, r);
            `CHK("ack", ROWS[i].ack, r.ack)
            `CHK("nak", ROWS[i].nak, r.nak)
            `CHK("rdata", ROWS[i].rdata, r.rdata)
        end
        `CHK("drive", 8'h18, ch_drive_en)
        `CHK("load1k", 8'h24, ch_load_1k)
        `CHK("load125k", 8'h42, ch_load_125k)
        `CHK("open", 8'h81, ~(ch_drive_en | ch_load_1k | ch_load_125k))
        `CHK("gain", 8'hFF, ch_gain)
        i_dpgs_host_model.cmd(1'b0, 1'b1, 5'h19, 16'h5A3C, r);
        `CHK("nv ack", 1'b1, r.ack)
        `CHK("ee req", 1'b1, ee_wr_req)
        `CHK("ee data", 16'h5A3C, ee_wr_data)
        `CHK("busy", 1'b1, write_active)
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h19, 16'h0000, r);
        `CHK("nv busy nak", 1'b1, r.nak)
        // A second program request while busy must be dropped
        i_dpgs_host_model.cmd(1'b0, 1'b1, 5'h19, 16'hFFFF, r);
        `CHK("nv busy wr nak", 1'b1, r.nak)
        `CHK("nv busy no req", 1'b0, ee_wr_req)
        i_dpgs_host_model.cmd(1'b0, 1'b1, 5'h09, 16'h0000, r);
        `CHK("vol busy ack", 1'b1, r.ack)
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
        `CHK("busy flag", 16'hFF40, r.rdata)
        `CHK("all driven", 8'hFF, ch_drive_en)
        // Program started 8 edges ago: still busy 2 edges before the end
        repeat (`DPGS_EE_WRITE_CYCLES - 10) @(posedge clk);
        #1;
        `CHK("busy late", 1'b1, write_active)
        repeat (3) @(posedge clk);
        #1;
        `CHK("busy over", 1'b0, write_active)
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
        `CHK("idle flag", 16'hFF00, r.rdata)
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h19, 16'h0000, r);
        `CHK("nv read", 16'h5A3C, r.rdata)
        @(posedge clk);
        #1;
        brownout_event = 1'b1;
        @(posedge clk);
        #1;
        brownout_event = 1'b0;
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
        `CHK("brownout", 16'hFF80, r.rdata)
        // Event lands on the same edge as the clearing read
        fork
            i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
            begin
                @(posedge clk);
                #1;
                brownout_event = 1'b1;
                @(posedge clk);
                #1;
                brownout_event = 1'b0;
            end
        join
        `CHK("race read", 16'hFF00, r.rdata)
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
        `CHK("race kept", 16'hFF80, r.rdata)
        // Mid-run reset must recall images and raise the flag again
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("rst rsp", 18'h0, rsp)
        `CHK("rst busy", 1'b0, write_active)
        `CHK("rst ee", 17'h0, {ee_wr_req, ee_wr_data})
        `CHK("rst drive", 8'h00, ch_drive_en)
        resetn = 1'b1;
        i_dpgs_host_model.cmd(1'b1, 1'b0, 5'h0A, 16'h0000, r);
        `CHK("rst flag", 16'hA580, r.rdata)
        `CHK("recall drive", 8'h88, ch_drive_en)
        `CHK("recall 1k", 8'h42, ch_load_1k)
        `CHK("recall 125k", 8'h21, ch_load_125k)
        `CHK("recall gain", 8'hA5, ch_gain)
        tally_and_finish();
    end
endmodule
